// ===== lpb_defines.vh
// Register map, field positions, reset values and timing counts
`ifndef LPB_DEFINES_VH
`define LPB_DEFINES_VH

// Register offsets
`define LPB_OFS_BLINK_CFG       8'h66
`define LPB_OFS_PORT_BASE       8'h10
`define LPB_OFS_PORT_LAST       8'h13
`define LPB_NUM_PORTS           4

// Reset values
`define LPB_RST_BLINK_CFG       8'h00
`define LPB_RST_PORT_SET        8'h00

// Configuration register fields
`define LPB_CFG_RATE_HI         4
`define LPB_CFG_RATE_LO         2
`define LPB_CFG_EXT_CLK_SEL     0

// Port setting fields
`define LPB_PS_INVALID          7
`define LPB_PS_HIGH_EN          6
`define LPB_PS_BLINK_MODE       5
`define LPB_PS_PWM_MSB          4

// Slave address
`define LPB_ADDR_UPPER          5'h13
`define LPB_ADDR_FIXED          7'h4c

// Strap connection codes
`define LPB_STRAP_GND           2'h0
`define LPB_STRAP_VDD           2'h1
`define LPB_STRAP_SDA           2'h2
`define LPB_STRAP_SCL           2'h3

// Timing
`define LPB_CLK_PERIOD_NS       10
`define LPB_INT_OSC_PERIOD_NS   31250
`define LPB_INT_OSC_CYCLES      (`LPB_INT_OSC_PERIOD_NS / `LPB_CLK_PERIOD_NS)
`define LPB_TICK_CNT_W          18
`define LPB_BLINK_SHIFT_MAX     18
`define LPB_BLINK_SHIFT_FAST    10
`define LPB_PWM_STEPS_W         5

`endif

// ===== lpb_port_drv.v
// Output encoder for one port: static, PWM or blink
`timescale 1ns/1ps
`default_nettype none
`include "lpb_defines.vh"

module lpb_port_drv (
    // Clock and reset
    input  wire       clk_sys,
    input  wire       srst,
    // Setting and shared timing
    input  wire [7:0] port_setting,
    input  wire [4:0] pwm_step,
    input  wire [3:0] blink_phase,
    // Port level
    output reg        port_out
);

    ////////////////////////////////////////////////////////////////////////
    reg port_next;

    always @* begin
        if (port_setting[`LPB_PS_INVALID]) begin
            port_next = 1'b0;
        end else if (port_setting[`LPB_PS_HIGH_EN] &&
                     port_setting[`LPB_PS_BLINK_MODE] &&
                     port_setting[`LPB_PS_PWM_MSB]) begin
            port_next = 1'b1;
        end else if (!port_setting[`LPB_PS_BLINK_MODE]) begin
            // Zero count never beats the step, so it stays low
            port_next = (pwm_step < port_setting[4:0]);
        end else begin
            port_next = (blink_phase < port_setting[3:0]);
        end
    end

    always @(posedge clk_sys) begin
        if (srst) begin
            port_out <= 1'b0;
        end else begin
            port_out <= port_next;
        end
    end

endmodule // lpb_port_drv

`default_nettype wire

// ===== lpb_led_port_ctrl.v
// Two-wire slave with port PWM and blink output control
`timescale 1ns/1ps
`default_nettype none
`include "lpb_defines.vh"

// Function
// - PWM port high n/32 of period
// - Zero count holds port static low
// - D6 D5 D4 set gives static high
// - Blink port high n/16 of period
// - Rate bits D4..D2 pick blink period
// - Blink divisor 262144 down to 1024
// - SDA open-drain in/out, SCL input only
// - Start, address, command, data, stop
// - Detect start and stop conditions
// - One bit per SCL pulse
// - Device acks own address, command and data bytes
// - Eighth address bit is direction
// - Upper address 10011, strap gives low
// - Fixed variant answers only 0x98
// - Command byte only sets pointer
// - Write data to pointer, auto-increment
// - Read from pointer, auto-increment
// - PWM period is 32 timing ticks
module lpb_led_port_ctrl #(
    parameter FIXED_ADDR_VARIANT = 0,
    parameter INT_OSC_CYCLES     = `LPB_INT_OSC_CYCLES
) (
    // Clock and reset
    input  wire       clk_sys,
    input  wire       srst,
    // Two-wire bus
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output wire       sda_oe,
    // Address strap connection code
    input  wire [1:0] addr_strap_pin,
    // External timing clock
    input  wire       ext_timing_clock_in,
    // Port outputs
    output wire [3:0] port_out
);

    ////////////////////////////////////////////////////////////////////////
    // States
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_ADDR  = 3'h1;
    localparam [2:0] ST_CMD   = 3'h2;
    localparam [2:0] ST_WDATA = 3'h3;
    localparam [2:0] ST_RDATA = 3'h4;

    localparam [3:0] BIT_ACK_DRIVE = 4'h8;
    localparam [3:0] BIT_ACK_CLOCK = 4'h9;

    // Divider terminal count, cut to the counter width on purpose
    localparam integer OSC_LAST_FULL = INT_OSC_CYCLES - 1;
    localparam [11:0]  OSC_LAST      = OSC_LAST_FULL[11:0];

    ////////////////////////////////////////////////////////////////////////
    // Registers
    reg [2:0]  state_reg;
    reg [3:0]  bit_cnt_reg;
    reg [7:0]  rx_reg;
    reg [7:0]  tx_reg;
    reg [7:0]  ptr_reg;
    reg        sda_drv_reg;
    reg        mack_reg;
    reg        scl_q_reg;
    reg        sda_q_reg;
    reg [7:0]  blink_cfg_reg;
    reg [7:0]  port_set_reg [0:`LPB_NUM_PORTS-1];
    reg [11:0] osc_cnt_reg;
    reg        ext_q_reg;
    reg [`LPB_TICK_CNT_W-1:0] tick_cnt_reg;

    wire       scl_rise;
    wire       scl_fall;
    wire       start_det;
    wire       stop_det;
    wire [6:0] own_addr;
    wire       addr_match;
    wire       ptr_is_port;
    wire [1:0] ptr_port_idx;
    reg  [1:0] strap_bits;
    reg  [7:0] rd_data;
    reg  [3:0] blink_phase;
    wire       int_tick;
    wire       ext_tick;
    wire       time_tick;

    ////////////////////////////////////////////////////////////////////////
    // Bus pins: SDA only ever pulled low, SCL never driven
    assign sda_out = 1'b0;
    assign sda_oe  = sda_drv_reg;

    assign scl_rise  = scl_in & ~scl_q_reg;
    assign scl_fall  = ~scl_in & scl_q_reg;
    assign start_det = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
    assign stop_det  = scl_in & scl_q_reg & ~sda_q_reg & sda_in;

    ////////////////////////////////////////////////////////////////////////
    // Slave address
    always @* begin
        case (addr_strap_pin)
            `LPB_STRAP_GND: strap_bits = 2'h0;
            `LPB_STRAP_VDD: strap_bits = 2'h1;
            `LPB_STRAP_SDA: strap_bits = 2'h2;
            `LPB_STRAP_SCL: strap_bits = 2'h3;
            default:        strap_bits = 2'h0;
        endcase
    end

    assign own_addr = (FIXED_ADDR_VARIANT != 0) ? `LPB_ADDR_FIXED
                    : {`LPB_ADDR_UPPER, strap_bits};
    assign addr_match = (rx_reg[7:1] == own_addr);

    ////////////////////////////////////////////////////////////////////////
    // Register read decode
    assign ptr_is_port  = (ptr_reg >= `LPB_OFS_PORT_BASE) &&
                          (ptr_reg <= `LPB_OFS_PORT_LAST);
    assign ptr_port_idx = ptr_reg[1:0];

    always @* begin
        if (ptr_reg == `LPB_OFS_BLINK_CFG) begin
            rd_data = blink_cfg_reg;
        end else if (ptr_is_port) begin
            rd_data = port_set_reg[ptr_port_idx];
        end else begin
            rd_data = 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial engine
    integer i;

    always @(posedge clk_sys) begin
        if (srst) begin
            state_reg     <= ST_IDLE;
            bit_cnt_reg   <= 4'h0;
            rx_reg        <= 8'h00;
            tx_reg        <= 8'h00;
            ptr_reg       <= 8'h00;
            sda_drv_reg   <= 1'b0;
            mack_reg      <= 1'b0;
            scl_q_reg     <= 1'b1;
            sda_q_reg     <= 1'b1;
            blink_cfg_reg <= `LPB_RST_BLINK_CFG;
            for (i = 0; i < `LPB_NUM_PORTS; i = i + 1) begin
                port_set_reg[i] <= `LPB_RST_PORT_SET;
            end
        end else begin
            scl_q_reg <= scl_in;
            sda_q_reg <= sda_in;
            if (start_det) begin
                state_reg   <= ST_ADDR;
                bit_cnt_reg <= 4'h0;
                sda_drv_reg <= 1'b0;
            end else if (stop_det) begin
                state_reg   <= ST_IDLE;
                bit_cnt_reg <= 4'h0;
                sda_drv_reg <= 1'b0;
            end else if (state_reg != ST_IDLE) begin
                if (scl_rise) begin
                    if (bit_cnt_reg < BIT_ACK_DRIVE) begin
                        rx_reg      <= {rx_reg[6:0], sda_in};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (bit_cnt_reg == BIT_ACK_CLOCK) begin
                        mack_reg <= ~sda_in;
                    end
                end else if (scl_fall) begin
                    if (bit_cnt_reg == BIT_ACK_DRIVE) begin
                        bit_cnt_reg <= BIT_ACK_CLOCK;
                        case (state_reg)
                            ST_ADDR: begin
                                if (addr_match) begin
                                    sda_drv_reg <= 1'b1;
                                end else begin
                                    state_reg <= ST_IDLE;
                                end
                            end
                            ST_CMD: begin
                                ptr_reg     <= rx_reg;
                                sda_drv_reg <= 1'b1;
                            end
                            ST_WDATA: begin
                                if (ptr_reg == `LPB_OFS_BLINK_CFG) begin
                                    blink_cfg_reg <= rx_reg;
                                end else if (ptr_is_port) begin
                                    port_set_reg[ptr_port_idx] <= rx_reg;
                                end
                                ptr_reg     <= ptr_reg + 8'h01;
                                sda_drv_reg <= 1'b1;
                            end
                            ST_RDATA: begin
                                sda_drv_reg <= 1'b0;
                                ptr_reg     <= ptr_reg + 8'h01;
                            end
                            default: begin
                                state_reg <= ST_IDLE;
                            end
                        endcase
                    end else if (bit_cnt_reg == BIT_ACK_CLOCK) begin
                        bit_cnt_reg <= 4'h0;
                        sda_drv_reg <= 1'b0;
                        case (state_reg)
                            ST_ADDR: begin
                                if (rx_reg[0]) begin
                                    state_reg   <= ST_RDATA;
                                    tx_reg      <= {rd_data[6:0], 1'b0};
                                    sda_drv_reg <= ~rd_data[7];
                                end else begin
                                    state_reg <= ST_CMD;
                                end
                            end
                            ST_CMD: begin
                                state_reg <= ST_WDATA;
                            end
                            ST_WDATA: begin
                                state_reg <= ST_WDATA;
                            end
                            ST_RDATA: begin
                                if (mack_reg) begin
                                    tx_reg      <= {rd_data[6:0], 1'b0};
                                    sda_drv_reg <= ~rd_data[7];
                                end else begin
                                    state_reg <= ST_IDLE;
                                end
                            end
                            default: begin
                                state_reg <= ST_IDLE;
                            end
                        endcase
                    end else if (state_reg == ST_RDATA) begin
                        sda_drv_reg <= ~tx_reg[7];
                        tx_reg      <= {tx_reg[6:0], 1'b0};
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timing source: internal divider or external clock edges
    assign int_tick  = (osc_cnt_reg == OSC_LAST);
    assign ext_tick  = ext_timing_clock_in & ~ext_q_reg;
    assign time_tick = blink_cfg_reg[`LPB_CFG_EXT_CLK_SEL] ? ext_tick
                     : int_tick;

    always @(posedge clk_sys) begin
        if (srst) begin
            osc_cnt_reg  <= 12'h000;
            ext_q_reg    <= 1'b0;
            tick_cnt_reg <= {`LPB_TICK_CNT_W{1'b0}};
        end else begin
            ext_q_reg <= ext_timing_clock_in;
            if (int_tick) begin
                osc_cnt_reg <= 12'h000;
            end else begin
                osc_cnt_reg <= osc_cnt_reg + 12'h001;
            end
            if (time_tick) begin
                tick_cnt_reg <= tick_cnt_reg + 18'h00001;
            end
        end
    end

    // Blink phase: top four bits of a 2^k tick window
    always @* begin
        case (blink_cfg_reg[`LPB_CFG_RATE_HI:`LPB_CFG_RATE_LO])
            3'h0:    blink_phase = tick_cnt_reg[17:14];
            3'h1:    blink_phase = tick_cnt_reg[16:13];
            3'h2:    blink_phase = tick_cnt_reg[15:12];
            3'h3:    blink_phase = tick_cnt_reg[14:11];
            3'h4:    blink_phase = tick_cnt_reg[13:10];
            3'h5:    blink_phase = tick_cnt_reg[12:9];
            3'h6:    blink_phase = tick_cnt_reg[11:8];
            3'h7:    blink_phase = tick_cnt_reg[9:6];
            default: blink_phase = 4'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Port drivers
    genvar g;
    generate
        for (g = 0; g < `LPB_NUM_PORTS; g = g + 1) begin : g_port
            lpb_port_drv u_port (
                .clk_sys      (clk_sys),
                .srst         (srst),
                .port_setting (port_set_reg[g]),
                .pwm_step     (tick_cnt_reg[4:0]),
                .blink_phase  (blink_phase),
                .port_out     (port_out[g])
            );
        end
    endgenerate

endmodule // lpb_led_port_ctrl

`default_nettype wire

// ===== lpb_led_port_ctrl_chk.sv
// Assertion checker for the LED port controller
`timescale 1ns/1ps
`default_nettype none
module lpb_chk #(
    parameter FIXED_ADDR_VARIANT = 0
) (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       srst,
    // Bus, strap and timing
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic [1:0] addr_strap_pin,
    input wire logic       ext_timing_clock_in,
    // Ports
    input wire logic [3:0] port_out
);
    logic       scl_q;
    logic       sda_q;
    logic       busy;
    logic [3:0] cnt;
    logic [7:0] sh;
    wire        hi2 = scl_in & scl_q;
    wire [6:0]  me = FIXED_ADDR_VARIANT ? 7'h4c : {5'h13, addr_strap_pin};
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys) begin
        scl_q <= srst | scl_in;
        sda_q <= srst | sda_in;
        if (srst | (hi2 & sda_q & !sda_in)) begin
            cnt  <= 4'h0;
            busy <= !srst;
        end else if (hi2 & !sda_q & sda_in) begin
            busy <= 1'b0;
        end else if (scl_in & !scl_q & (cnt != 4'hf)) begin
            cnt <= cnt + 4'h1;
            if (cnt < 4'h8) begin
                sh <= {sh[6:0], sda_in};
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    a_sda_low_only: assert property (sda_out == 1'b0)
        else $error("sda output not low");
    a_rst_quiet: assert property ($fell(srst) |-> !sda_oe && !port_out)
        else $error("outputs active after reset");
    a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in))
        else $error("sda drive began outside scl low");
    a_oe_fall_low: assert property ($fell(sda_oe) |-> !scl_in)
        else $error("sda drive ended while scl high");
    a_oe_in_frame: assert property ($rose(sda_oe) |-> busy)
        else $error("sda driven outside a frame");
    a_addr_quiet: assert property (busy && hi2 && cnt inside {[4'h1:4'h8]} |-> !sda_oe)
        else $error("sda driven during address byte");
    a_addr_ack: assert property (busy && hi2 && cnt == 4'h9 && sh[7:1] == me |-> sda_oe)
        else $error("own address not acknowledged");
    a_addr_nack: assert property (busy && cnt == 4'h9 && sh[7:1] != me |-> !sda_oe)
        else $error("foreign address acknowledged");
    a_ack_release: assert property (busy && cnt == 4'h9 && !sh[0] && $fell(scl_in) |-> ##[1:2] !sda_oe)
        else $error("address ack not released");
    c_ack: cover property (hi2 && cnt == 4'h9 && sda_oe);
    c_read: cover property (hi2 && cnt > 4'h9 && sda_oe);
    c_port: cover property ($rose(port_out[1]));
endmodule // lpb_chk
bind lpb_led_port_ctrl lpb_chk #(
    .FIXED_ADDR_VARIANT(FIXED_ADDR_VARIANT)
) i_lpb_chk (
    .clk_sys(clk_sys), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_pin(addr_strap_pin),
    .ext_timing_clock_in(ext_timing_clock_in), .port_out(port_out));
`default_nettype wire

// ===== lpb_i2c_master.sv
// Two-wire bus master model for the LED port controller
`timescale 1ns/1ps
`default_nettype none
module lpb_i2c_master (
    // Clock
    input wire logic clk_sys,
    // Bus lines
    output var logic scl,
    output var logic sda_rel,
    input wire logic sda
);
    initial begin
        scl     = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic half();
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_rel = b;
        half();
        scl = 1'b1;
        half();
        r = sda;
        scl = 1'b0;
    endtask
    task automatic start();
        sda_rel = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_rel = 1'b0;
        half();
        scl = 1'b0;
    endtask
    task automatic stop();
        sda_rel = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_rel = 1'b1;
        half();
    endtask
    task automatic xfer(input logic [7:0] d, input logic ack_in,
                        output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q = {q[6:0], r};
        end
        bit_io(ack_in, ack);
    endtask
endmodule // lpb_i2c_master
`default_nettype wire

// ===== lpb_led_port_ctrl_tb.sv
// Self-checking bench for the LED port controller
`timescale 1ns/1ps
`default_nettype none
module lpb_led_port_ctrl_tb;
    logic       clk_sys = 1'b0;
    logic       srst = 1'b1;
    logic       ext_clk = 1'b0;
    logic       ext_run = 1'b0;
    logic [1:0] strap = 2'h0;
    int         fail_count = 0;
    int         comparisons = 0;
    int         seed = 64;
    logic [7:0] wb [5];
    logic [7:0] rb [4];
    logic [7:0] q;
    logic       ack;
    wire        scl;
    wire        sda_rel;
    wire        sda_out;
    wire        sda_oe;
    wire [3:0]  port_out;
    wire        sda = sda_rel & ~(sda_oe & ~sda_out);
    always #5 clk_sys = ~clk_sys;
    always #100 if (ext_run) ext_clk = ~ext_clk;
    lpb_led_port_ctrl #(.INT_OSC_CYCLES(4)) i_lpb_led_port_ctrl (
        .clk_sys(clk_sys), .srst(srst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_pin(strap),
        .ext_timing_clock_in(ext_clk), .port_out(port_out));
    lpb_i2c_master i_lpb_i2c_master (
        .clk_sys(clk_sys), .scl(scl), .sda_rel(sda_rel), .sda(sda));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (fail_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic send(input logic [7:0] d, input logic ai);
        i_lpb_i2c_master.xfer(d, ai, q, ack);
    endtask
    task automatic wr(input logic [7:0] ptr, input int f, input int n);
        i_lpb_i2c_master.start();
        send({5'h13, strap, 1'b0}, 1'b1);
        check("addr ack", ack, 0);
        send(ptr, 1'b1);
        check("cmd ack", ack, 0);
        for (int i = f; i < f + n; i++) begin
            send(wb[i], 1'b1);
            check("data ack", ack, 0);
        end
        i_lpb_i2c_master.stop();
    endtask
    task automatic rdp(input logic [7:0] ptr, input int n);
        wr(ptr, 0, 0);
        i_lpb_i2c_master.start();
        send({5'h13, strap, 1'b1}, 1'b1);
        check("read addr ack", ack, 0);
        for (int i = 0; i < n; i++) begin
            send(8'hff, i == n - 1);
            rb[i] = q;
        end
        i_lpb_i2c_master.stop();
    endtask
    function automatic int exp_hi(input logic [7:0] s, input int w);
        if (s[6:4] == 3'b111) return w;
        if (s[5]) return s[3:0] * w / 16;
        return s[4:0] * w / 32;
    endfunction
    task automatic measure(input int w);
        int hc [4] = '{0, 0, 0, 0};
        repeat (w) begin
            @(negedge clk_sys);
            for (int g = 0; g < 4; g++) hc[g] += port_out[g];
        end
        for (int g = 0; g < 4; g++) begin
            check("port high", hc[g], exp_hi(wb[g], w));
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] v;
        repeat (12) @(negedge clk_sys);
        srst = 1'b0;
        for (int s = 0; s < 4; s++) begin
            strap = s[1:0];
            i_lpb_i2c_master.start();
            send({5'h13, strap, 1'b0} ^ (8'h02 << s), 1'b1);
            check("foreign nack", ack, 1);
            i_lpb_i2c_master.stop();
            wr(8'h66, 0, 0);
        end
        for (int c = 0; c < 8; c++) begin
            wb[4] = {3'h0, c[2:0], 2'h0};
            wr(8'h66, 4, 1);
            rdp(8'h66, 1);
            check("rate code", rb[0], wb[4]);
        end
        for (int r = 0; r < 4; r++) begin
            v = $random(seed);
            wb[4] = r == 3 ? 8'h1d : (r == 2 ? 8'h18 : 8'h1c);
            wb[0] = r ? {3'h0, v[4:0]} : 8'h1f;
            wb[1] = r ? {4'h2, v[8:5]} : 8'h2f;
            wb[2] = {4'h7, v[12:9]};
            wb[3] = {2'h0, v[13], 5'h00};
            wr(8'h66, 4, 1);
            wr(8'h10, 0, 4);
            rdp(8'h10, 4);
            for (int g = 0; g < 4; g++) check("setting", rb[g], wb[g]);
            ext_run = r == 3;
            repeat (400) @(negedge clk_sys);
            measure(r == 3 ? 20480 : (r == 2 ? 16384 : 4096));
        end
        wb[0] = 8'h55;
        wr(8'h20, 0, 1);
        rdp(8'h20, 1);
        check("unmapped read", rb[0], 0);
        srst = 1'b1;
        repeat (2) @(negedge clk_sys);
        srst = 1'b0;
        rdp(8'h10, 4);
        for (int g = 0; g < 4; g++) check("port reset", rb[g], 0);
        rdp(8'h66, 1);
        check("cfg reset", rb[0], 0);
        stop_test();
    end
    initial begin
        repeat (90000) @(posedge clk_sys);
        fail_count++;
        stop_test();
    end
endmodule // lpb_led_port_ctrl_tb
`default_nettype wire
